/* File: usb_ep_pkg.sv */
// shared constants and carriers for the endpoint control block
package usb_ep_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_EP      = 5;
    localparam int NUM_DMA     = 2;
    localparam int IDX_W       = 9;
    localparam int DESC_ADDR_W = 13;
    localparam int DESC_LEN_W  = 10;
    localparam int XFER_CNT_W  = 11;
    localparam int EP_SEL_W    = 3;

    // ------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_EP_CTRL [NUM_EP] =
        '{9'h134, 9'h144, 9'h154, 9'h1a4, 9'h1b4};
    localparam logic [IDX_W-1:0] IDX_DESC_ADDR_H = 9'h160;
    localparam logic [IDX_W-1:0] IDX_DESC_ADDR_L = 9'h161;
    localparam logic [IDX_W-1:0] IDX_DESC_LEN_H  = 9'h162;
    localparam logic [IDX_W-1:0] IDX_DESC_LEN_L  = 9'h163;
    localparam logic [IDX_W-1:0] IDX_DMA_CTRL [NUM_DMA] =
        '{9'h170, 9'h172};
    localparam logic [IDX_W-1:0] IDX_TRIM        = 9'h1be;
    localparam logic [IDX_W-1:0] IDX_ADDR_MODE   = 9'h1e1;

    // ------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE        = 8'h00;
    localparam logic [7:0] RST_TRIM        = 8'h00;
    localparam int         SLEW_LSB        = 4;
    localparam int         TERM_LSB        = 0;
    localparam int         MANUAL_ADDR_BIT = 4;
    localparam int         ADDR_HI_W       = DESC_ADDR_W - 8;
    localparam int         LEN_HI_W        = DESC_LEN_W - 8;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic autoNak;
        logic shortEn;
        logic shortDis;
        logic toggle;
        logic tglSet;
        logic tglClr;
        logic nak;
        logic stall;
    } ep_ctrl_byte_t;

    typedef struct packed {
        logic xferActive;
        logic xferDoneOk;
        logic rxShort;
        logic txShortSent;
        logic toggleFlip;
    } ep_evt_t;

    typedef struct packed {
        logic respStall;
        logic respNak;
        logic shortEn;
        logic toggle;
    } ep_resp_t;

    typedef struct packed {
        logic                start;
        logic                done;
        logic                fifoEmpty;
        logic                belowMax;
        logic                epIsIn;
        logic [EP_SEL_W-1:0] epSel;
    } dma_evt_t;

endpackage

/* File: ep_ctrl_unit.sv */
// per-endpoint nak, stall, toggle and short-packet control
`timescale 1ns/1ps
`default_nettype none
module ep_ctrl_unit (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rstn,
    // register side
    input  wire logic                     wrEn,
    input  wire usb_ep_pkg::ep_ctrl_byte_t wrData,
    output var  usb_ep_pkg::ep_ctrl_byte_t rdData,
    // engine side
    input  wire usb_ep_pkg::ep_evt_t      evt,
    input  wire logic                     arm,
    output var  usb_ep_pkg::ep_resp_t     resp
);
    logic autoNak_reg, shortDis_reg, shortEn_reg, shortEn_next;
    logic toggle_reg, toggle_next, nak_reg, nak_next;
    logic nakPend_reg, nakPend_next, stall_reg, stall_next;
    logic stallEff_reg, stallEff_next;
    wire  autoNakSet = evt.xferDoneOk & (autoNak_reg
                     | (~shortDis_reg & evt.rxShort));
    wire  nakWr1     = wrEn & wrData.nak;
    wire  nakSet     = autoNakSet | ((nakWr1 | nakPend_reg) & ~evt.xferActive);

    // set wins over a software clear in the same cycle
    assign nak_next      = nakSet ? 1'b1 : ((wrEn & ~wrData.nak) ? 1'b0 : nak_reg);
    assign nakPend_next  = wrEn ? (nakWr1 & evt.xferActive)
                                : (nakPend_reg & evt.xferActive);
    assign stall_next    = wrEn ? wrData.stall : stall_reg;
    // a running transaction keeps the stall it started with
    assign stallEff_next = evt.xferActive ? stallEff_reg : stall_next;
    // strobes are not stored; clear beats set
    assign toggle_next   = (wrEn & wrData.tglClr) ? 1'b0 :
                           (wrEn & wrData.tglSet) ? 1'b1 :
                           evt.toggleFlip ? ~toggle_reg : toggle_reg;
    assign shortEn_next  = (arm | (wrEn & wrData.shortEn)) ? 1'b1 :
                           (evt.txShortSent | wrEn) ? 1'b0 : shortEn_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {autoNak_reg, shortDis_reg, shortEn_reg, toggle_reg} <= 4'h0;
            {nak_reg, nakPend_reg, stall_reg, stallEff_reg} <= 4'h0;
        end else begin
            autoNak_reg  <= wrEn ? wrData.autoNak : autoNak_reg;
            shortDis_reg <= wrEn ? wrData.shortDis : shortDis_reg;
            shortEn_reg  <= shortEn_next;
            toggle_reg   <= toggle_next;
            nak_reg      <= nak_next;
            nakPend_reg  <= nakPend_next;
            stall_reg    <= stall_next;
            stallEff_reg <= stallEff_next;
        end
    end

    assign rdData = '{autoNak: autoNak_reg, shortEn: shortEn_reg,
                      shortDis: shortDis_reg, toggle: toggle_reg,
                      tglSet: 1'b0, tglClr: 1'b0,
                      nak: nak_reg, stall: stall_reg};
    // stall overrides nak
    assign resp = '{respStall: stallEff_reg,
                    respNak: ~stallEff_reg & nak_reg,
                    shortEn: shortEn_reg, toggle: toggle_reg};

    sequence seqDoneShort;
        evt.xferDoneOk && evt.rxShort && !shortDis_reg;
    endsequence
    AST_SHORT_NAK: assert property (@(posedge clk) disable iff (!rstn)
        seqDoneShort |=> nak_reg) else $error("short packet did not force nak");
    AST_AUTO_NAK: assert property (@(posedge clk) disable iff (!rstn)
        evt.xferDoneOk && autoNak_reg |=> nak_reg)
        else $error("auto nak missing after transfer");
    AST_NAK_HELD: assert property (@(posedge clk) disable iff (!rstn)
        nakWr1 && evt.xferActive && !nak_reg && !autoNakSet |=> !nak_reg)
        else $error("nak applied during transaction");
    AST_STALL_WINS: assert property (@(posedge clk) disable iff (!rstn)
        !evt.xferActive && !wrEn && stall_reg |=> resp.respStall && !resp.respNak)
        else $error("nak with stall");
    AST_TGL_CLR_WINS: assert property (@(posedge clk) disable iff (!rstn)
        wrEn && wrData.tglClr |=> !rdData.toggle) else $error("toggle not cleared");
endmodule
`default_nettype wire

/* File: dma_flag_unit.sv */
// per dma channel running flag and short-packet arming
`timescale 1ns/1ps
`default_nettype none
module dma_flag_unit (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rstn,
    // control
    input  wire logic                      autoShort,
    input  wire usb_ep_pkg::dma_evt_t      dma,
    // status
    output logic                           running,
    output logic [usb_ep_pkg::NUM_EP-1:0] armVec
);
    logic endSeen_reg, running_reg;
    logic [usb_ep_pkg::NUM_EP-1:0] arm_reg;
    // the flag only falls once the fifo drained after the end
    wire runClr = (endSeen_reg | dma.done) & dma.fifoEmpty & ~dma.start;
    wire armHit = dma.done & autoShort & dma.epIsIn & dma.belowMax;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            endSeen_reg <= 1'b0;
            running_reg <= 1'b0;
            arm_reg     <= '0;
        end else begin
            endSeen_reg <= ~dma.start & ~runClr & (endSeen_reg | dma.done);
            running_reg <= dma.start | (running_reg & ~runClr);
            for (int i = 0; i < usb_ep_pkg::NUM_EP; i++) begin
                arm_reg[i] <= armHit && (dma.epSel == i[usb_ep_pkg::EP_SEL_W-1:0]);
            end
        end
    end
    assign running = running_reg;
    assign armVec  = arm_reg;

    AST_RUN_SET: assert property (@(posedge clk) disable iff (!rstn)
        dma.start |=> running) else $error("running flag not set on start");
    AST_ARM: assert property (@(posedge clk) disable iff (!rstn)
        armHit |=> (armVec != '0)) else $error("short packet not armed");
endmodule
`default_nettype wire

/* File: usb_device_endpoint_control.sv */
// endpoint control top: wishbone registers, descriptor counters, trims
`timescale 1ns/1ps
`default_nettype none
module usb_device_endpoint_control (
    // clock and reset
    input  wire logic                                   clk,
    input  wire logic                                   rstn,
    // wishbone slave
    input  wire logic                                   wb_cyc_i,
    input  wire logic                                   wb_stb_i,
    input  wire logic                                   wb_we_i,
    input  wire logic [11:0]                            wb_adr_i,
    input  wire logic [3:0]                             wb_sel_i,
    input  wire logic [31:0]                            wb_dat_i,
    output logic [31:0]                                 wb_dat_o,
    output logic                                        wb_ack_o,
    // endpoint engine
    input  wire usb_ep_pkg::ep_evt_t [usb_ep_pkg::NUM_EP-1:0]  epEvt,
    output usb_ep_pkg::ep_resp_t [usb_ep_pkg::NUM_EP-1:0]      epResp,
    // dma channels
    input  wire usb_ep_pkg::dma_evt_t [usb_ep_pkg::NUM_DMA-1:0] dmaEvt,
    output logic [usb_ep_pkg::NUM_DMA-1:0]              dmaRunning,
    // descriptor reply
    input  wire logic                                   descReplyActive,
    input  wire logic                                   ep0InDone,
    input  wire logic [usb_ep_pkg::XFER_CNT_W-1:0]      ep0InBytes,
    output logic [usb_ep_pkg::DESC_ADDR_W-1:0]          descStartAddr,
    output logic [usb_ep_pkg::DESC_LEN_W-1:0]           descLength,
    // transceiver and address setup
    output logic [1:0]                                  txSlewTrim,
    output logic [1:0]                                  lineTermTrim,
    output logic                                        manualAddressSelect
);
    localparam int NE = usb_ep_pkg::NUM_EP;
    localparam int ND = usb_ep_pkg::NUM_DMA;
    localparam int AW = usb_ep_pkg::DESC_ADDR_W;
    localparam int LW = usb_ep_pkg::DESC_LEN_W;
    localparam int HA = usb_ep_pkg::ADDR_HI_W;
    localparam int HL = usb_ep_pkg::LEN_HI_W;

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    logic        ack_reg;
    logic [7:0]  rdByte;
    logic [31:0] rdData_reg;
    wire         req    = wb_cyc_i & wb_stb_i;
    // writes land on the acking edge, once per cycle and only when wb_sel_i[0] is set
    wire         wrAck  = req & wb_we_i & ack_reg & wb_sel_i[0];
    wire [usb_ep_pkg::IDX_W-1:0] idx = wb_adr_i[10:2];
    wire [7:0]   wByte  = wb_dat_i[7:0];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_reg    <= 1'b0;
            rdData_reg <= 32'h0000_0000;
        end else begin
            ack_reg    <= req & ~ack_reg;
            rdData_reg <= {24'h00_0000, rdByte};
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdData_reg;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire hitAddrH = (idx == usb_ep_pkg::IDX_DESC_ADDR_H);
    wire hitAddrL = (idx == usb_ep_pkg::IDX_DESC_ADDR_L);
    wire hitLenH  = (idx == usb_ep_pkg::IDX_DESC_LEN_H);
    wire hitLenL  = (idx == usb_ep_pkg::IDX_DESC_LEN_L);
    wire hitTrim  = (idx == usb_ep_pkg::IDX_TRIM);
    wire hitMode  = (idx == usb_ep_pkg::IDX_ADDR_MODE);

    // ------------------------------------------------------------
    // endpoint control registers
    // ------------------------------------------------------------
    usb_ep_pkg::ep_ctrl_byte_t epRd [NE];
    logic [7:0]  epRdOr [NE+1];
    logic [NE-1:0] epArm;
    logic [NE-1:0] dmaArm [ND];
    assign epRdOr[0] = 8'h00;

    generate
        for (genvar e = 0; e < NE; e++) begin : gEp
            wire hit = (idx == usb_ep_pkg::IDX_EP_CTRL[e]);
            logic armAny;
            always_comb begin
                armAny = 1'b0;
                for (int d = 0; d < ND; d++) begin
                    armAny = armAny | dmaArm[d][e];
                end
            end
            assign epArm[e] = armAny;
            ep_ctrl_unit uEp (
                .clk    (clk),
                .rstn   (rstn),
                .wrEn   (wrAck & hit),
                .wrData (usb_ep_pkg::ep_ctrl_byte_t'(wByte)),
                .rdData (epRd[e]),
                .evt    (epEvt[e]),
                .arm    (epArm[e]),
                .resp   (epResp[e])
            );
            assign epRdOr[e+1] = epRdOr[e] | (hit ? 8'(epRd[e]) : 8'h00);
        end
    endgenerate

    // ------------------------------------------------------------
    // dma channel flags
    // ------------------------------------------------------------
    logic [ND-1:0] autoShort_reg;
    logic [7:0]    dmaRdOr [ND+1];
    assign dmaRdOr[0] = 8'h00;

    generate
        for (genvar d = 0; d < ND; d++) begin : gDma
            wire hit = (idx == usb_ep_pkg::IDX_DMA_CTRL[d]);
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    autoShort_reg[d] <= 1'b0;
                end else if (wrAck & hit) begin
                    autoShort_reg[d] <= wByte[6];
                end
            end
            dma_flag_unit uDma (
                .clk       (clk),
                .rstn      (rstn),
                .autoShort (autoShort_reg[d]),
                .dma       (dmaEvt[d]),
                .running   (dmaRunning[d]),
                .armVec    (dmaArm[d])
            );
            assign dmaRdOr[d+1] = dmaRdOr[d] |
                (hit ? {dmaRunning[d], autoShort_reg[d], 6'h00} : 8'h00);
        end
    endgenerate

    // ------------------------------------------------------------
    // descriptor reply counters
    // ------------------------------------------------------------
    logic [AW-1:0] descAddr_reg, descAddr_next;
    logic [LW-1:0] descLen_reg, descLen_next;
    wire  descStep = descReplyActive & ep0InDone;
    wire [AW-1:0] addrAdv = descAddr_reg + AW'(ep0InBytes);
    // never wraps below zero when the last packet overshoots
    wire [LW-1:0] lenLeft = ({1'b0, ep0InBytes} >= (LW+1)'(descLen_reg))
                          ? '0 : descLen_reg - LW'(ep0InBytes);

    // software write has priority over a hardware step in the same cycle
    assign descAddr_next =
        (wrAck & hitAddrH) ? {wByte[HA-1:0], descAddr_reg[7:0]} :
        (wrAck & hitAddrL) ? {descAddr_reg[AW-1:8], wByte} :
        descStep ? addrAdv : descAddr_reg;
    assign descLen_next =
        (wrAck & hitLenH) ? {wByte[HL-1:0], descLen_reg[7:0]} :
        (wrAck & hitLenL) ? {descLen_reg[LW-1:8], wByte} :
        descStep ? lenLeft : descLen_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            descAddr_reg <= '0;
            descLen_reg  <= '0;
        end else begin
            descAddr_reg <= descAddr_next;
            descLen_reg  <= descLen_next;
        end
    end
    assign descStartAddr = descAddr_reg;
    assign descLength    = descLen_reg;

    // ------------------------------------------------------------
    // transceiver trim and address mode
    // ------------------------------------------------------------
    logic [7:0] trim_reg;
    logic       manual_reg;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trim_reg   <= usb_ep_pkg::RST_TRIM;
            manual_reg <= 1'b0;
        end else begin
            if (wrAck & hitTrim) begin
                trim_reg <= wByte;
            end
            if (wrAck & hitMode) begin
                manual_reg <= wByte[usb_ep_pkg::MANUAL_ADDR_BIT];
            end
        end
    end
    assign txSlewTrim          = trim_reg[usb_ep_pkg::SLEW_LSB +: 2];
    assign lineTermTrim        = trim_reg[usb_ep_pkg::TERM_LSB +: 2];
    assign manualAddressSelect = manual_reg;

    // ------------------------------------------------------------
    // read mux; the mode register is write-only and reads zero
    // ------------------------------------------------------------
    wire [7:0] trimRd = {2'b00, trim_reg[usb_ep_pkg::SLEW_LSB +: 2],
                         2'b00, trim_reg[usb_ep_pkg::TERM_LSB +: 2]};
    wire [7:0] descRd =
        hitAddrH ? {{(8-HA){1'b0}}, descAddr_reg[AW-1:8]} :
        hitAddrL ? descAddr_reg[7:0] :
        hitLenH  ? {{(8-HL){1'b0}}, descLen_reg[LW-1:8]} :
        hitLenL  ? descLen_reg[7:0] : 8'h00;
    assign rdByte = epRdOr[NE] | dmaRdOr[ND] | descRd |
                    (hitTrim ? trimRd : 8'h00);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence seqReq;
        req && !ack_reg;
    endsequence
    sequence seqAckOnce;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    AST_WB_ACK: assert property (@(posedge clk) disable iff (!rstn)
        seqReq |=> seqAckOnce) else $error("bus answer not a one-cycle ack");
    AST_DESC_ADDR_ADV: assert property (@(posedge clk) disable iff (!rstn)
        descStep && !wrAck |=> descStartAddr ==
            $past(descStartAddr) + AW'($past(ep0InBytes)))
        else $error("descriptor address did not advance");
    AST_DESC_LEN_DROP: assert property (@(posedge clk) disable iff (!rstn)
        descStep && !wrAck && ({1'b0, ep0InBytes} < (LW+1)'(descLen_reg))
        |=> descLength == $past(descLength) - LW'($past(ep0InBytes)))
        else $error("descriptor length did not drop");
    AST_DESC_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        !descStep && !wrAck |=> $stable(descStartAddr) && $stable(descLength))
        else $error("descriptor counters moved idle");
    AST_SLEW: assert property (@(posedge clk) disable iff (!rstn)
        wrAck && hitTrim |=> txSlewTrim == $past(wByte[5:4]))
        else $error("slew trim not driven");
    AST_TERM: assert property (@(posedge clk) disable iff (!rstn)
        wrAck && hitTrim |=> lineTermTrim == $past(wByte[1:0]))
        else $error("termination trim not driven");
    AST_MANUAL: assert property (@(posedge clk) disable iff (!rstn)
        wrAck && hitMode |=> manualAddressSelect == $past(wByte[4]))
        else $error("address mode not applied");
    AST_MODE_READ_ZERO: assert property (@(posedge clk) disable iff (!rstn)
        hitMode |=> wb_dat_o == 32'h0000_0000)
        else $error("write-only register read nonzero");
endmodule
`default_nettype wire

/* File: usb_host_model.sv */
// engine-side model: transactions and dma events toward the endpoint block
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
    // clock
    input  wire logic                                          clk,
    // events toward the block
    output var  usb_ep_pkg::ep_evt_t  [usb_ep_pkg::NUM_EP-1:0]  epEvt,
    output var  usb_ep_pkg::dma_evt_t [usb_ep_pkg::NUM_DMA-1:0] dmaEvt
);
    initial begin
        epEvt = '0;
        dmaEvt = '0;
    end
    // one transaction, busy for len cycles, then a normal end
    task automatic xfer(input int ep, input int len, input logic rxS, input logic txS);
        @(posedge clk);
        epEvt[ep].xferActive <= 1'b1;
        repeat (len) @(posedge clk);
        epEvt[ep].xferActive <= 1'b0;
        epEvt[ep].xferDoneOk <= 1'b1;
        epEvt[ep].rxShort <= rxS;
        epEvt[ep].txShortSent <= txS;
        @(posedge clk);
        epEvt[ep] <= '0;
    endtask
    // one hardware flip of the sequence bit
    task automatic flip(input int ep);
        @(posedge clk);
        epEvt[ep].toggleFlip <= 1'b1;
        @(posedge clk);
        epEvt[ep].toggleFlip <= 1'b0;
    endtask
    // start or done pulse; the fifo level stays until the next call
    task automatic dma(input int ch, input logic st, input logic dn, input logic mt, input int ep);
        @(posedge clk);
        dmaEvt[ch] <= '{st, dn, mt, 1'b1, 1'b1, 3'(ep)};
        @(posedge clk);
        dmaEvt[ch].start <= 1'b0;
        dmaEvt[ch].done <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: usb_device_endpoint_control_tb.sv */
// self-checking bench for the endpoint control block
`timescale 1ns/1ps
`default_nettype none
module usb_device_endpoint_control_tb;
    logic        clk, rstn, cyc, stb, we, descAct, inDone, manual, ack;
    logic [3:0]  sel;
    logic [11:0] adr;
    logic [31:0] datI, datO;
    logic [10:0] inBytes;
    logic [1:0]  running, slew, term;
    logic [12:0] dAddr, a0;
    logic [9:0]  dLen, l0;
    logic [8:0]  ec;
    logic [7:0]  q, v;
    int          fails, checkCount, seed, e, b, ch;
    usb_ep_pkg::ep_evt_t  [usb_ep_pkg::NUM_EP-1:0]  epEvt;
    usb_ep_pkg::ep_resp_t [usb_ep_pkg::NUM_EP-1:0]  epResp;
    usb_ep_pkg::dma_evt_t [usb_ep_pkg::NUM_DMA-1:0] dmaEvt;
    localparam logic [7:0] TGL_WR [5] = '{8'h08, 8'h00, 8'h0c, 8'h08, 8'h04};
    localparam logic [7:0] TGL_RD [5] = '{8'h10, 8'h10, 8'h00, 8'h10, 8'h00};
    // control byte, short packet, expected nak
    localparam logic [9:0] AN [6] = '{10'h003, 10'h082, 10'h283, 10'h203, 10'h201, 10'h000};
    usb_device_endpoint_control DUT (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO),
        .wb_ack_o(ack), .epEvt(epEvt), .epResp(epResp), .dmaEvt(dmaEvt), .dmaRunning(running),
        .descReplyActive(descAct), .ep0InDone(inDone), .ep0InBytes(inBytes),
        .descStartAddr(dAddr), .descLength(dLen), .txSlewTrim(slew), .lineTermTrim(term),
        .manualAddressSelect(manual));
    usb_host_model host (.clk(clk), .epEvt(epEvt), .dmaEvt(dmaEvt));
    always #2 clk = ~clk;
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checkCount++;
        if (got !== ex) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic wb(input logic w, input logic [8:0] idx, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {1'b0, idx, 2'b00};
        datI <= {24'h0, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = datO[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    function automatic logic [9:0] lenAfter(input logic [9:0] l, input int n);
        return (l > n) ? 10'(l - n) : 10'h000;
    endfunction
    task automatic closeOut();
        $display("comparisons %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        seed = 32'hf2f63a0c;
        {clk, rstn, cyc, stb, we, descAct, inDone} = '0;
        {sel, adr, datI, inBytes} = {4'h1, 55'h0};
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            wb(0, i < 5 ? usb_ep_pkg::IDX_EP_CTRL[i] : 9'(usb_ep_pkg::IDX_DESC_ADDR_H + i - 5), 0);
            chk("resetByte", 0, q);
        end
        chk("resetPorts", 0, {dAddr, dLen, running, slew, term, manual});
        wb(1, 9'h1ff, 8'hff);
        wb(0, 9'h1ff, 8'h00);
        chk("unmapped", 0, q);
        $display("reset test done");
        e = $unsigned($random(seed)) % 5;
        ec = usb_ep_pkg::IDX_EP_CTRL[e];
        for (int i = 0; i < 5; i++) begin
            wb(1, ec, TGL_WR[i]);
            wb(0, ec, 8'h00);
            chk("toggle", {TGL_RD[i], TGL_RD[i][4]}, {q, epResp[e].toggle});
        end
        host.flip(e);
        @(posedge clk);
        chk("toggleFlip", 1, epResp[e].toggle);
        for (int i = 0; i < 6; i++) begin
            wb(1, ec, AN[i][9:2]);
            host.xfer(e, 2, AN[i][1], 1'b0);
            @(posedge clk);
            chk("autoNak", AN[i][0], epResp[e].respNak);
        end
        for (int i = 0; i < 2; i++) begin
            fork
                host.xfer(e, 8, 1'b0, 1'b0);
                begin
                    repeat (2) @(posedge clk);
                    wb(1, ec, i ? 8'h03 : 8'h02);
                    @(posedge clk);
                    chk("heldMid", 0, {epResp[e].respStall, epResp[e].respNak ^ i});
                end
            join
            @(posedge clk);
            chk("afterEnd", i ? 2 : 1, {epResp[e].respStall, epResp[e].respNak});
        end
        wb(1, ec, 8'h00);
        wb(1, ec, 8'h02);
        @(posedge clk);
        chk("nakAtOnce", 1, epResp[e].respNak);
        wb(1, ec, 8'h00);
        $display("endpoint tests done");
        for (int i = 0; i < 2; i++) begin
            a0 = i ? 13'h11ff : 13'($unsigned($random(seed)) % 32'h1200);
            l0 = i ? 10'h3ff : 10'($random(seed));
            b = i ? 64 : $unsigned($random(seed)) % 700 + 1;
            wb(1, usb_ep_pkg::IDX_DESC_ADDR_H, 8'(a0 >> 8));
            wb(1, usb_ep_pkg::IDX_DESC_ADDR_L, a0[7:0]);
            wb(1, usb_ep_pkg::IDX_DESC_LEN_H, 8'(l0 >> 8));
            wb(1, usb_ep_pkg::IDX_DESC_LEN_L, l0[7:0]);
            @(posedge clk);
            chk("descLoad", {a0, l0}, {dAddr, dLen});
            descAct <= 1'b1;
            inDone <= 1'b1;
            inBytes <= 11'(b);
            @(posedge clk);
            inDone <= 1'b0;
            @(posedge clk);
            chk("descStep", {13'(a0 + b), lenAfter(l0, b)}, {dAddr, dLen});
        end
        descAct <= 1'b0;
        $display("descriptor test done");
        ch = $unsigned($random(seed)) % 2;
        wb(1, usb_ep_pkg::IDX_DMA_CTRL[ch], 8'h40);
        host.dma(ch, 1'b1, 1'b0, 1'b0, e);
        @(posedge clk);
        chk("running", 1, running[ch]);
        host.dma(ch, 1'b0, 1'b1, 1'b0, e);
        repeat (3) @(posedge clk);
        chk("armed", 3, {epResp[e].shortEn, running[ch]});
        host.dma(ch, 1'b0, 1'b0, 1'b1, e);
        repeat (2) @(posedge clk);
        chk("drained", 0, running[ch]);
        host.xfer(e, 2, 1'b0, 1'b0);
        @(posedge clk);
        chk("fullKeeps", 1, epResp[e].shortEn);
        host.xfer(e, 2, 1'b0, 1'b1);
        @(posedge clk);
        chk("shortClears", 0, epResp[e].shortEn);
        $display("dma test done");
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            v = {2'b00, 2'(i), 2'b00, 2'(3 - i)} | (v & 8'hcc);
            wb(1, usb_ep_pkg::IDX_TRIM, v);
            wb(1, usb_ep_pkg::IDX_ADDR_MODE, {3'b000, v[0], 4'h0});
            @(posedge clk);
            chk("trim", {v[5:4], v[1:0], v[0]}, {slew, term, manual});
        end
        sel <= 4'he;
        wb(1, usb_ep_pkg::IDX_TRIM, 8'h00);
        wb(0, usb_ep_pkg::IDX_ADDR_MODE, 8'h00);
        chk("noSelAndMode", {v[5:4], v[1:0], 8'h00}, {slew, term, q});
        $display("trim test done");
        closeOut();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        closeOut();
    end
endmodule
`default_nettype wire
